// ===== rtl/irq_enable_pkg.sv
/*
 * Package for the switch-input interrupt enable block: register indices,
 * field positions, reset values and the carrier structs.
 * Assumes a single 10 MHz clock domain with synchronous reset.
 */
package irq_enable_pkg;

    localparam int unsigned DATA_W = 24;
    localparam int unsigned ADDR_W = 6;

    // register indices as addressed by the serial host port
    localparam logic [ADDR_W-1:0] EDGE_SEL_UPPER_ADDR = 6'h23;
    localparam logic [ADDR_W-1:0] GLOBAL_EN_ADDR      = 6'h24;
    localparam logic [ADDR_W-1:0] LOW_INPUTS_EN_ADDR  = 6'h25;

    localparam logic [DATA_W-1:0] EDGE_SEL_RESET   = 24'h000000;
    localparam logic [DATA_W-1:0] GLOBAL_EN_RESET  = 24'h000000;
    localparam logic [DATA_W-1:0] LOW_INPUTS_RESET = 24'h000000;
    localparam logic [DATA_W-1:0] GLOBAL_EN_MASK   = 24'h000FFF;

    // input index held at bit pair 0 of the edge-select register
    localparam int unsigned EDGE_FIRST_INPUT = 12;
    localparam int unsigned EDGE_INPUTS      = 12;

    // global enable bit positions
    localparam int unsigned CONVERTER_ERROR_GATE_BIT = 11;
    localparam int unsigned WETTING_ERROR_GATE_BIT   = 10;
    localparam int unsigned SUPPLY_SENSE1_GATE_BIT   = 9;
    localparam int unsigned SUPPLY_SENSE0_GATE_BIT   = 8;
    localparam int unsigned CHECKSUM_DONE_GATE_BIT   = 7;
    localparam int unsigned UNDERVOLTAGE_GATE_BIT    = 6;
    localparam int unsigned SUPPLY_HIGH_GATE_BIT     = 5;
    localparam int unsigned THERMAL_WARNING_GATE_BIT = 4;
    localparam int unsigned THERMAL_SHUTDOWN_GATE_BIT = 3;
    localparam int unsigned SWITCH_CHANGE_GATE_BIT   = 2;
    localparam int unsigned PARITY_ERROR_GATE_BIT    = 1;
    localparam int unsigned SERIAL_FAIL_GATE_BIT     = 0;
    localparam int unsigned GLOBAL_EVENTS            = 12;

    // edge selector encodings
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } reg_rsp_s;

    // pending diagnostic and supply events, one bit per global enable bit
    typedef struct packed {
        logic converter_error;
        logic wetting_error;
        logic supply_sense1;
        logic supply_sense0;
        logic checksum_done;
        logic undervoltage;
        logic supply_high;
        logic thermal_warning;
        logic thermal_shutdown;
        logic switch_change;
        logic parity_error;
        logic serial_fail;
    } event_vec_s;

endpackage : irq_enable_pkg

// ===== rtl/switch_input_interrupt_enables.sv
/*
 * Interrupt enable logic of the switch detection device: per-input comparator
 * edge selection for inputs 12 to 23, and the global event enable register
 * that gates pending diagnostic events onto the active-low interrupt line.
 * Assumes the serial host port decoder delivers one-cycle register requests
 * in the clk domain, and that comparator results and event flags come from
 * logic on the same clock.
 */
//
// Behaviour
// - selector 1h: interrupt only on an upward comparator crossing.
// - selector 2h: interrupt only on a downward comparator crossing.
// - selector 3h: interrupt on both crossings.
// - selector 0h: never a comparator interrupt for that input.
// - inputs 16-18 use threshold group 16-19, selectors at bits 9-8, 11-10, 13-12.
// - inputs 15-12 use threshold group 12-15, selectors at bits 7-6 down to 1-0.
// - bit 11 gates converter error events onto the interrupt line.
// - bit 10 gates wetting-current error events onto the interrupt line.
// - bit 9 gates supply-sense channel one crossings.
// - bit 8 gates supply-sense channel zero crossings.
// - bit 7 gates checksum calculation completion.
// - bit 6 gates supply undervoltage events.
// - bit 5 gates supply overvoltage events.
// - bit 4 gates thermal warning events.
// - bit 3 gates thermal shutdown events.
// - bit 2 gates switch-state-change events.
// - bit 1 gates parity failure events.
// - bit 0 gates serial-interface failure events.
// - global enable register at 24h, resets to zero, all sources blocked.
// - edge-selector register at 23h resets to zero.
// - selectors for inputs 19-23 use the same encoding; 20-23 own threshold.
`timescale 1ns/100ps
`default_nettype none

module switch_input_interrupt_enables
    import irq_enable_pkg::*;
#(
    parameter int unsigned INPUTS = EDGE_INPUTS
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire reg_req_s          reg_req,
    output var  reg_rsp_s          reg_rsp,
    input  wire logic [INPUTS-1:0] comp_above,
    input  wire event_vec_s        events_pending,
    output var  logic [INPUTS-1:0] comp_edge_event,
    output var  logic [DATA_W-1:0] low_inputs_enable,
    output var  logic              irq_n
);

    logic [DATA_W-1:0] edge_sel_q;
    logic [DATA_W-1:0] global_en_q;
    logic [DATA_W-1:0] low_inputs_q;
    logic [INPUTS-1:0] comp_prev_q;
    logic [INPUTS-1:0] edge_hit_d;
    logic [INPUTS-1:0] edge_event_q;
    logic              comp_valid_q;
    logic              irq_n_q;
    reg_rsp_s          rsp_q;
    logic              wr_edge_sel;
    logic              wr_global_en;
    logic              wr_low_inputs;
    logic [DATA_W-1:0] rd_word;
    event_vec_s        gate;
    event_vec_s        gated;
    logic              any_gated;

    // one index compare per register, shared by the write and read paths
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
        addr_is = (addr == target);
    endfunction : addr_is

    // one decode per selector; each input lane uses only its own result
    function automatic logic edge_match(input logic [1:0] sel,
                                        input logic       prev,
                                        input logic       now);
        logic rise;
        logic fall;
        rise = !prev && now;
        fall = prev && !now;
        unique case (sel)
            EDGE_NONE:    edge_match = 1'b0;
            EDGE_RISING:  edge_match = rise;
            EDGE_FALLING: edge_match = fall;
            EDGE_BOTH:    edge_match = rise || fall;
        endcase
    endfunction : edge_match

    // selector pair k belongs to input 12+k, so 16..18 land on bits 9-8..13-12
    // and 12..15 on bits 1-0..7-6; grouping follows the threshold banks
    genvar k;
    generate
        for (k = 0; k < INPUTS; k++) begin : g_lane
            always_comb begin
                edge_hit_d[k] = edge_match(edge_sel_q[2*k +: 2],
                                           comp_prev_q[k],
                                           comp_above[k]);
            end
        end
    endgenerate

    // unmapped indices fall through every strobe, so such writes vanish
    always_comb begin
        wr_edge_sel   = reg_req.wr && addr_is(reg_req.addr, EDGE_SEL_UPPER_ADDR);
        wr_global_en  = reg_req.wr && addr_is(reg_req.addr, GLOBAL_EN_ADDR);
        wr_low_inputs = reg_req.wr && addr_is(reg_req.addr, LOW_INPUTS_EN_ADDR);
    end

    // selector register: every bit pair is live, nothing reserved
    always_ff @(posedge clk) begin
        if (rst) begin
            edge_sel_q <= EDGE_SEL_RESET;
        end else if (wr_edge_sel) begin
            edge_sel_q <= reg_req.wdata;
        end
    end

    // reserved upper bits never store, so they cannot leak into a read
    always_ff @(posedge clk) begin
        if (rst) begin
            global_en_q <= GLOBAL_EN_RESET;
        end else if (wr_global_en) begin
            global_en_q <= reg_req.wdata & GLOBAL_EN_MASK;
        end
    end

    // stored and exported only; its selectors act outside this block
    always_ff @(posedge clk) begin
        if (rst) begin
            low_inputs_q <= LOW_INPUTS_RESET;
        end else if (wr_low_inputs) begin
            low_inputs_q <= reg_req.wdata;
        end
    end

    // unmapped indices answer zero rather than stale data
    always_comb begin
        if (addr_is(reg_req.addr, EDGE_SEL_UPPER_ADDR)) begin
            rd_word = edge_sel_q;
        end else if (addr_is(reg_req.addr, GLOBAL_EN_ADDR)) begin
            rd_word = global_en_q & GLOBAL_EN_MASK;
        end else if (addr_is(reg_req.addr, LOW_INPUTS_EN_ADDR)) begin
            rd_word = low_inputs_q;
        end else begin
            rd_word = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= reg_req.rd;
            // read beside a write returns the old word
            if (reg_req.rd) begin
                rsp_q.rdata <= rd_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            comp_prev_q <= '0;
        end else begin
            comp_prev_q <= comp_above;
        end
    end

    // first sample after reset only seeds history, so no false crossing
    always_ff @(posedge clk) begin
        if (rst) begin
            comp_valid_q <= 1'b0;
        end else begin
            comp_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            edge_event_q <= '0;
        end else begin
            edge_event_q <= comp_valid_q ? edge_hit_d : '0;
        end
    end

    // struct bit order matches the enable register, msb first
    assign gate = event_vec_s'(global_en_q[GLOBAL_EVENTS-1:0]);

    always_comb begin
        gated.converter_error  = events_pending.converter_error  && gate.converter_error;
        gated.wetting_error    = events_pending.wetting_error    && gate.wetting_error;
        gated.supply_sense1    = events_pending.supply_sense1    && gate.supply_sense1;
        gated.supply_sense0    = events_pending.supply_sense0    && gate.supply_sense0;
        gated.checksum_done    = events_pending.checksum_done    && gate.checksum_done;
        gated.undervoltage     = events_pending.undervoltage     && gate.undervoltage;
        gated.supply_high      = events_pending.supply_high      && gate.supply_high;
        gated.thermal_warning  = events_pending.thermal_warning  && gate.thermal_warning;
        gated.thermal_shutdown = events_pending.thermal_shutdown && gate.thermal_shutdown;
        gated.switch_change    = events_pending.switch_change    && gate.switch_change;
        gated.parity_error     = events_pending.parity_error     && gate.parity_error;
        gated.serial_fail      = events_pending.serial_fail      && gate.serial_fail;
    end

    assign any_gated = |gated;

    // level output: sources hold their pending flags until cleared elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= !any_gated;
        end
    end

    assign reg_rsp           = rsp_q;
    assign comp_edge_event   = edge_event_q;
    assign low_inputs_enable = low_inputs_q;
    assign irq_n             = irq_n_q;

endmodule : switch_input_interrupt_enables

`default_nettype wire

// ===== tb/host_model.sv
/* host side of the register port: one-cycle write and read strobes
   assumes the caller enters each task just after a rising edge */
`timescale 1ns/100ps
`default_nettype none
module host_model import irq_enable_pkg::*; (
    input  wire logic     clk,
    output var  reg_req_s req,
    input  wire reg_rsp_s rsp
);
    initial req = '0;
    // released fields are inverted so stale values never look valid
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) #1;
        req <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge clk) #1;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic ok);
        req <= '{1'b0, 1'b1, a, 24'h000000};
        @(posedge clk) #1;
        req <= '{1'b0, 1'b0, ~a, 24'hFFFFFF};
        ok = rsp.valid;
        d = rsp.rdata;
        @(posedge clk) #1;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ===== tb/irq_enable_properties.sv
/* assertions on the ports of the interrupt enable block
   assumes it is bound onto switch_input_interrupt_enables */
`timescale 1ns/100ps
`default_nettype none
module irq_enable_checker import irq_enable_pkg::*; #(
    parameter int unsigned INPUTS = EDGE_INPUTS
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire reg_req_s          reg_req,
    input wire reg_rsp_s          reg_rsp,
    input wire logic [INPUTS-1:0] comp_above,
    input wire event_vec_s        events_pending,
    input wire logic [INPUTS-1:0] comp_edge_event,
    input wire logic [DATA_W-1:0] low_inputs_enable,
    input wire logic              irq_n
);
    logic [DATA_W-1:0] sel_q, en_q, low_q, rd_d;
    logic [INPUTS-1:0] prev_q, exp_d;
    logic              seed_q;
    // shadows built from the request stream alone, never from internals
    always_ff @(posedge clk) begin
        if (rst) begin
            {sel_q, en_q, low_q} <= '0;
        end else if (reg_req.wr) begin
            if (reg_req.addr == EDGE_SEL_UPPER_ADDR) sel_q <= reg_req.wdata;
            if (reg_req.addr == GLOBAL_EN_ADDR) en_q <= reg_req.wdata & GLOBAL_EN_MASK;
            if (reg_req.addr == LOW_INPUTS_EN_ADDR) low_q <= reg_req.wdata;
        end
    end
    // first sample after reset only seeds the history
    always_ff @(posedge clk) begin
        prev_q <= comp_above;
        seed_q <= !rst;
    end
    always_comb begin
        for (int k = 0; k < INPUTS; k++) begin
            exp_d[k] = seed_q && ((sel_q[2*k] && comp_above[k] && !prev_q[k])
                       || (sel_q[2*k+1] && !comp_above[k] && prev_q[k]));
        end
    end
    assign rd_d = (reg_req.addr == EDGE_SEL_UPPER_ADDR) ? sel_q :
                  (reg_req.addr == GLOBAL_EN_ADDR) ? en_q :
                  (reg_req.addr == LOW_INPUTS_EN_ADDR) ? low_q : '0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_read; reg_req.rd; endsequence
    sequence s_gate_read; reg_req.rd && reg_req.addr == GLOBAL_EN_ADDR; endsequence
    property p_rd_valid; s_read |=> reg_rsp.valid; endproperty
    property p_no_valid; !reg_req.rd |=> !reg_rsp.valid; endproperty
    property p_rd_data; s_read |=> reg_rsp.rdata == $past(rd_d); endproperty
    property p_rsvd; s_gate_read |=> reg_rsp.rdata[23:12] == 12'h000; endproperty
    property p_irq; 1'b1 |=> irq_n == !$past(|(en_q[11:0] & events_pending)); endproperty
    property p_gate_block; en_q == '0 |=> irq_n; endproperty
    property p_edge; 1'b1 |=> comp_edge_event == $past(exp_d); endproperty
    property p_low; low_inputs_enable == low_q; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    a_no_valid: assert property (p_no_valid) else $error("answer without read");
    a_rd_data: assert property (p_rd_data) else $error("read data wrong");
    a_rsvd: assert property (p_rsvd) else $error("upper gate bits not zero");
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
    a_gate_block: assert property (p_gate_block) else $error("line low while gated");
    a_edge: assert property (p_edge) else $error("edge event wrong");
    a_low: assert property (p_low) else $error("low input enables wrong");
endmodule : irq_enable_checker
bind switch_input_interrupt_enables irq_enable_checker #(.INPUTS(INPUTS)) i_chk (.clk, .rst,
    .reg_req, .reg_rsp, .comp_above, .events_pending, .comp_edge_event, .low_inputs_enable,
    .irq_n);
`default_nettype wire

// ===== tb/testbench.sv
/* self-checking bench for the interrupt enable block
   assumes host_model drives the register port and the checker is bound */
`timescale 1ns/100ps
`default_nettype none
module testbench import irq_enable_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, ok, irq_n;
    reg_req_s    req;
    reg_rsp_s    rsp;
    logic [11:0] cmp = '0, ev = '0, edg, bit_v;
    logic [23:0] low, d, en, lo_exp;
    int          fails = 0, check_count = 0, seed = 90, k;
    always #50 clk = ~clk;
    switch_input_interrupt_enables i_dut (.clk, .rst, .reg_req(req), .reg_rsp(rsp),
        .comp_above(cmp), .events_pending(event_vec_s'(ev)), .comp_edge_event(edg),
        .low_inputs_enable(low), .irq_n);
    host_model i_host (.clk, .req, .rsp);
    function automatic logic exp_irq(input logic [23:0] e, input logic [11:0] p);
        return !(|(e[11:0] & p));
    endfunction : exp_irq
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        for (int a = 'h23; a < 'h27; a++) begin
            i_host.rd(6'(a), d, ok);
            check(24'(ok), 24'h000001);
            check(d, 24'h000000);
        end
        i_host.wr(GLOBAL_EN_ADDR, 24'hFFFFFF);
        i_host.rd(GLOBAL_EN_ADDR, d, ok);
        check(d, 24'h000FFF);
        // one bit enabled, one bit blocked, then random mixes
        for (int i = 0; i < 48; i++) begin
            bit_v = 12'(1 << (i % 12));
            en = (i < 12) ? 24'(bit_v) : (i < 24) ? 24'(~bit_v) : 24'($random(seed));
            ev = (i < 24) ? bit_v : 12'($random(seed));
            i_host.wr(GLOBAL_EN_ADDR, en);
            check(24'(irq_n), 24'(exp_irq(en, ev)));
        end
        // every code at every selector position, one rise and one fall
        for (int i = 0; i < 48; i++) begin
            k = i % 12;
            en = 24'($random(seed));
            en[2*k +: 2] = 2'(i / 12);
            i_host.wr(EDGE_SEL_UPPER_ADDR, en);
            cmp[k] = 1'b1;
            @(posedge clk) #1;
            check(24'(edg), en[2*k] ? 24'(1 << k) : 24'h0);
            cmp[k] = 1'b0;
            @(posedge clk) #1;
            check(24'(edg), en[2*k+1] ? 24'(1 << k) : 24'h0);
        end
        lo_exp = '0;
        for (int i = 0; i < 80; i++) begin
            d = 24'($random(seed));
            {ev, cmp} = d;
            i_host.wr(6'h23 + 6'(i % 4), d);
            if (i % 4 == 2) lo_exp = d;
            check(low, lo_exp);
        end
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
